// ==== hw/asr_pkg.sv ====
// constants and types for the sample output and range flag block
package asr_pkg;
  localparam int CODE_W = 14;
  localparam int DIFF_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_MHZ = 25;
  // input difference in lsb units, full scale is plus or minus 8192
  localparam logic signed [DIFF_W-1:0] NEG_FS = 16'she000;
  localparam logic signed [DIFF_W-1:0] POS_FS = 16'sh2000;
  localparam logic [CODE_W-1:0] CODE_MIN = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_MID = 14'h2000;
  localparam logic [CODE_W-1:0] CODE_MAX = 14'h3fff;
  localparam int MSB_POS = CODE_W - 1;
  // strap levels seen on the reference select input
  localparam logic [1:0] STRAP_TO_GND = 2'h0;
  localparam logic [1:0] STRAP_TO_REF = 2'h1;
  localparam logic [1:0] STRAP_TO_SUPPLY = 2'h2;

  typedef enum logic [2:0] {
    REF_1V = 3'h1,
    REF_2V5 = 3'h2,
    REF_EXT = 3'h4
  } asr_ref_mode_t;

  typedef struct packed {
    logic outOfRange;
    logic [CODE_W-1:0] code;
  } asr_word_t;

  localparam int WORD_W = $bits(asr_word_t);
endpackage

// ==== hw/asr_fifo.sv ====
// sample fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module asr_fifo
#(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic full
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("asr_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic wrFire;
  logic rdFire;

  assign full = (count_r == (AW+1)'(DEPTH));
  assign inReady = !full;
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign wrFire = inValid && inReady;
  assign rdFire = outValid && outReady;

  always_ff @(posedge clk_sys)
  begin
    if (wrFire)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (wrFire)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (rdFire)
        rdPtr_r <= rdPtr_r + 1'b1;
      if (wrFire && !rdFire)
        count_r <= count_r + 1'b1;
      else if (rdFire && !wrFire)
        count_r <= count_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== hw/asr_sample_out.sv ====
// converter digital side: encoding, range flag, output pipeline, reference strap
`timescale 1ns/10ps
`default_nettype none
module asr_sample_out
#(
  parameter int FIFO_DEPTH = asr_pkg::FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic convClk,
  input wire logic signed [asr_pkg::DIFF_W-1:0] inDiff,
  input wire logic outHold,
  input wire logic [1:0] refStrap,
  output logic [asr_pkg::CODE_W-1:0] sampleData,
  output logic outOfRangeFlag,
  output logic sampleStrobe,
  output logic sampleLost,
  output asr_pkg::asr_ref_mode_t refMode,
  output logic intRefAmpOn
);
  import asr_pkg::*;
  localparam int HELD_W = $clog2(FIFO_DEPTH + 2);
  localparam logic [HELD_W-1:0] HELD_MAX = HELD_W'(FIFO_DEPTH + 1);

  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("asr_sample_out: fifo depth below 2");
    if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
      $error("asr_sample_out: fifo depth not a power of two");
    if (DIFF_W < CODE_W + 2)
      $error("asr_sample_out: input difference too narrow for the code");
  end

  function automatic asr_word_t encodeSample(input logic signed [DIFF_W-1:0] d);
    asr_word_t w;
    logic [DIFF_W-1:0] shifted;
    shifted = d - NEG_FS;
    w.outOfRange = (d < NEG_FS) || (d >= POS_FS);
    if (d <= NEG_FS)
      w.code = CODE_MIN;
    else if (d >= POS_FS - 16'sh0001)
      w.code = CODE_MAX;
    else
      w.code = shifted[CODE_W-1:0];
    return w;
  endfunction

  function automatic asr_ref_mode_t decodeStrap(input logic [1:0] s);
    asr_ref_mode_t m;
    m = REF_2V5;
    if (s == STRAP_TO_REF)
      m = REF_1V;
    else if (s == STRAP_TO_SUPPLY)
      m = REF_EXT;
    return m;
  endfunction

  logic convPrev_r;
  logic rise;
  logic fall;
  logic acceptRise;
  logic [HELD_W-1:0] heldWords_r;
  asr_word_t pipeWord_r;
  logic pipeValid_r;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoFull;
  logic rdFire;
  logic [WORD_W-1:0] fifoOutData;
  asr_word_t rdWord;
  logic [CODE_W-1:0] sampleData_r;
  logic outOfRangeFlag_r;
  logic sampleStrobe_r;
  logic sampleLost_r;
  asr_ref_mode_t refMode_r;
  logic intRefAmpOn_r;
  logic strapTaken_r;

  // both edges of the converter clock carry timing
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      convPrev_r <= 1'b0;
    else
      convPrev_r <= convClk;
  end

  assign rise = convClk && !convPrev_r;
  assign fall = !convClk && convPrev_r;
  assign acceptRise = rise && !(pipeValid_r && !fifoInReady);

  // rising edge samples and encodes; flag is built with the code it belongs to
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pipeWord_r <= '0;
      pipeValid_r <= 1'b0;
    end
    else if (acceptRise)
    begin
      pipeWord_r <= encodeSample(inDiff);
      pipeValid_r <= 1'b1;
    end
    else if (fifoInReady)
      pipeValid_r <= 1'b0;
  end

  // a sample that finds the stage blocked by a full fifo is dropped
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sampleLost_r <= 1'b0;
    else
      sampleLost_r <= rise && pipeValid_r && !fifoInReady;
  end

  asr_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) asr_fifo_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inValid(pipeValid_r),
    .inReady(fifoInReady),
    .inData(pipeWord_r),
    .outValid(fifoOutValid),
    .outReady(fall && !outHold),
    .outData(fifoOutData),
    .full(fifoFull)
  );

  assign rdWord = asr_word_t'(fifoOutData);
  assign rdFire = fifoOutValid && fall && !outHold;

  // falling edge presents code and flag as one word
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sampleData_r <= CODE_MIN;
      outOfRangeFlag_r <= 1'b0;
    end
    else if (rdFire)
    begin
      sampleData_r <= rdWord.code;
      outOfRangeFlag_r <= rdWord.outOfRange;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sampleStrobe_r <= 1'b0;
    else
      sampleStrobe_r <= rdFire;
  end

  // strap is caught once, on the first edge after reset release
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      strapTaken_r <= 1'b0;
      refMode_r <= REF_2V5;
      intRefAmpOn_r <= 1'b1;
    end
    else if (!strapTaken_r)
    begin
      strapTaken_r <= 1'b1;
      refMode_r <= decodeStrap(refStrap);
      intRefAmpOn_r <= (decodeStrap(refStrap) != REF_EXT);
    end
  end

  // words held in stage and fifo together, for the checks below
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      heldWords_r <= '0;
    else if (acceptRise && !rdFire)
      heldWords_r <= heldWords_r + 1'b1;
    else if (rdFire && !acceptRise)
      heldWords_r <= heldWords_r - 1'b1;
  end

  assign sampleData = sampleData_r;
  assign outOfRangeFlag = outOfRangeFlag_r;
  assign sampleStrobe = sampleStrobe_r;
  assign sampleLost = sampleLost_r;
  assign refMode = refMode_r;
  assign intRefAmpOn = intRefAmpOn_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // checks on encoding and range flag
  code_mid_zero_a: assert property (
    acceptRise && inDiff == 16'sh0000
    |=> pipeWord_r.code == CODE_MID && !pipeWord_r.outOfRange)
    else $error("zero input did not give mid code");

  code_in_span_a: assert property (
    acceptRise && inDiff > NEG_FS && inDiff < POS_FS - 16'sh0001
    |=> pipeWord_r.code == {!$past(inDiff[MSB_POS]), $past(inDiff[MSB_POS-1:0])}
    && !pipeWord_r.outOfRange)
    else $error("in-span input gave wrong code");

  code_clip_ends_a: assert property (
    acceptRise && (inDiff >= POS_FS - 16'sh0001 || inDiff <= NEG_FS)
    |=> pipeWord_r.code == (($past(inDiff) >= POS_FS - 16'sh0001) ? CODE_MAX : CODE_MIN))
    else $error("clipped input gave wrong end code");

  out_code_clipped_a: assert property (
    sampleStrobe_r && outOfRangeFlag_r
    |-> sampleData_r == CODE_MIN || sampleData_r == CODE_MAX)
    else $error("out-of-range word without an end code");

  flag_data_pair_a: assert property (
    rdFire |=> sampleStrobe_r && sampleData_r == $past(rdWord.code)
    && outOfRangeFlag_r == $past(rdWord.outOfRange))
    else $error("flag and data did not update together");

  data_hold_a: assert property (
    !sampleStrobe_r |-> $stable(sampleData_r) && $stable(outOfRangeFlag_r))
    else $error("output word moved without a strobe");

  pipe_hold_full_a: assert property (
    pipeValid_r && !fifoInReady |=> pipeValid_r && $stable(pipeWord_r))
    else $error("staged word lost while the fifo was full");

  flag_span_edge_a: assert property (
    acceptRise
    |=> pipeWord_r.outOfRange == ($past(inDiff) < NEG_FS || $past(inDiff) >= POS_FS))
    else $error("range flag wrong for input");

  flag_hold_until_a: assert property (
    outOfRangeFlag_r && !rdFire |=> outOfRangeFlag_r)
    else $error("range flag fell without a new conversion output");

  flag_fall_cause_a: assert property (
    $fell(outOfRangeFlag_r) |-> $past(rdFire) && !$past(rdWord.outOfRange))
    else $error("range flag fell without an in-range word");

  // checks on the output pipeline
  edge_phase_use_a: assert property (
    sampleStrobe_r |-> $past(fall) && !convPrev_r)
    else $error("output moved outside a falling clock edge");

  strobe_single_a: assert property (
    sampleStrobe_r |=> !sampleStrobe_r)
    else $error("output strobe longer than one cycle");

  lost_single_a: assert property (
    sampleLost_r |=> !sampleLost_r)
    else $error("lost pulse longer than one cycle");

  accept_load_a: assert property (
    acceptRise |=> pipeValid_r)
    else $error("accepted sample not staged");

  drop_when_full_a: assert property (
    sampleLost_r |-> $past(rise) && $past(heldWords_r) == HELD_MAX)
    else $error("sample dropped with room left");

  full_drops_a: assert property (
    rise && heldWords_r == HELD_MAX |=> sampleLost_r)
    else $error("sample beyond capacity not reported");

  held_cap_a: assert property (
    heldWords_r <= HELD_MAX)
    else $error("more words held than fifo and stage can keep");

  hold_blocks_read_a: assert property (
    outHold |=> !sampleStrobe_r)
    else $error("word output while the receiver stalled");

  // checks on the reference strap
  ref_strap_mode_a: assert property (
    $rose(strapTaken_r) |-> refMode_r == (($past(refStrap) == STRAP_TO_REF) ? REF_1V
    : (($past(refStrap) == STRAP_TO_SUPPLY) ? REF_EXT : REF_2V5))
    && intRefAmpOn_r == ($past(refStrap) != STRAP_TO_SUPPLY))
    else $error("reference mode does not follow strap");

  ref_pre_strap_a: assert property (
    !strapTaken_r |-> refMode_r == REF_2V5 && intRefAmpOn_r)
    else $error("reference mode left its reset value early");

  ref_mode_fixed_a: assert property (
    strapTaken_r |=> $stable(refMode_r) && $stable(intRefAmpOn_r))
    else $error("reference mode changed after the strap was taken");

  ref_onehot_a: assert property (
    $onehot(refMode_r))
    else $error("reference mode not one-hot");

  over_out_c: cover property (sampleStrobe_r && outOfRangeFlag_r && sampleData_r[MSB_POS]);
  under_out_c: cover property (sampleStrobe_r && outOfRangeFlag_r && !sampleData_r[MSB_POS]);
  fifo_full_c: cover property (fifoFull ##1 sampleLost_r);
  flag_clear_c: cover property (outOfRangeFlag_r ##[1:200] !outOfRangeFlag_r);
  stall_drain_c: cover property (outHold ##1 !outHold ##[1:40] sampleStrobe_r);
endmodule
`default_nettype wire

// ==== verif/asr_receiver.sv ====
// receiver model: captures each word and decodes range and two's complement
`timescale 1ns/10ps
`default_nettype none
module asr_receiver
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [asr_pkg::CODE_W-1:0] sampleData,
  input wire logic outOfRangeFlag,
  input wire logic sampleStrobe,
  output asr_pkg::asr_word_t capWord,
  output logic [1:0] rangeClass,
  output logic [asr_pkg::CODE_W-1:0] twosCode
);
  import asr_pkg::*;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      capWord <= '0;
    else if (sampleStrobe)
      capWord <= {outOfRangeFlag, sampleData};
  assign twosCode = {~capWord.code[MSB_POS], capWord.code[MSB_POS-1:0]};
  assign rangeClass = !capWord.outOfRange ? 2'h0 : (capWord.code[MSB_POS] ? 2'h2 : 2'h1);
endmodule
`default_nettype wire

// ==== verif/asr_sample_out_tb_top.sv ====
// bench for the sample output block with its receiver model
`timescale 1ns/10ps
`default_nettype none
module asr_sample_out_tb_top;
  import asr_pkg::*;
  logic clk_sys, rstn, convClk, outHold;
  logic signed [DIFF_W-1:0] inDiff;
  logic [1:0] refStrap, rangeClass;
  logic [CODE_W-1:0] sampleData, twosCode;
  logic outOfRangeFlag, sampleStrobe, sampleLost, intRefAmpOn;
  asr_ref_mode_t refMode;
  asr_word_t capWord;
  int fail_count = 0;
  int total_checks = 0;
  int lostCount = 0;
  asr_word_t gotQ[$];
  asr_sample_out asr_sample_out_inst (.clk_sys(clk_sys), .rstn(rstn), .convClk(convClk),
    .inDiff(inDiff), .outHold(outHold), .refStrap(refStrap), .sampleData(sampleData),
    .outOfRangeFlag(outOfRangeFlag), .sampleStrobe(sampleStrobe), .sampleLost(sampleLost),
    .refMode(refMode), .intRefAmpOn(intRefAmpOn));
  asr_receiver asr_receiver_inst (.clk_sys(clk_sys), .rstn(rstn), .sampleData(sampleData),
    .outOfRangeFlag(outOfRangeFlag), .sampleStrobe(sampleStrobe), .capWord(capWord),
    .rangeClass(rangeClass), .twosCode(twosCode));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
  begin
    if (sampleStrobe === 1'b1)
      gotQ.push_back({outOfRangeFlag, sampleData});
    if (sampleLost === 1'b1)
      lostCount++;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] strap);
    rstn = 1'b0;
    refStrap = strap;
    gotQ.delete();
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
  endtask
  // one conversion, both phases two system cycles long
  task automatic pulse(input logic signed [15:0] d);
    @(negedge clk_sys);
    inDiff = d;
    convClk = 1'b1;
    repeat (2) @(negedge clk_sys);
    convClk = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic pop(output asr_word_t w);
    int n;
    n = 0;
    while (gotQ.size() == 0 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (gotQ.size() == 0)
    begin
      fail_count++;
      $display("ERROR pop expected a word seen none");
      end_sim();
    end
    else
      w = gotQ.pop_front();
  endtask
  task automatic strap_modes();
    asr_ref_mode_t m[4] = '{REF_2V5, REF_1V, REF_EXT, REF_2V5};
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      repeat (2) @(negedge clk_sys);
      check("mode", {13'h0, m[s]}, {13'h0, refMode});
      check("amp", {15'h0, m[s] != REF_EXT}, {15'h0, intRefAmpOn});
    end
  endtask
  task automatic encode_table();
    logic signed [15:0] d[6] = '{-16'sd8193, -16'sd8192, 16'sd0, 16'sd8191, 16'sd8192, 16'sd0};
    logic [14:0] e[6] = '{15'h4000, 15'h0000, 15'h2000, 15'h3fff, 15'h7fff, 15'h2000};
    asr_word_t w;
    for (int i = 0; i < 6; i++)
    begin
      pulse(d[i]);
      pop(w);
      check("word", {1'b0, e[i]}, {1'b0, w});
      @(negedge clk_sys);
      check("class", e[i][14] ? (e[i][13] ? 16'h2 : 16'h1) : 16'h0, {14'h0, rangeClass});
      check("twos", {2'h0, ~e[i][13], e[i][12:0]}, {2'h0, twosCode});
    end
  endtask
  task automatic stall_fill();
    asr_word_t w;
    outHold = 1'b1;
    lostCount = 0;
    for (int i = 0; i < 12; i++)
      pulse(16'(i * 100));
    check("lost", 16'(12 - FIFO_DEPTH - 1), 16'(lostCount));
    check("held", 16'h0, 16'(gotQ.size()));
    outHold = 1'b0;
    for (int i = 0; i < FIFO_DEPTH + 1; i++)
    begin
      pulse(-16'sd100);
      pop(w);
      check("order", 16'(16'h2000 + i * 100), {1'b0, w});
    end
  endtask
  initial
  begin
    rstn = 1'b0;
    convClk = 1'b0;
    inDiff = '0;
    outHold = 1'b0;
    refStrap = STRAP_TO_GND;
    strap_modes();
    do_reset(STRAP_TO_GND);
    encode_table();
    stall_fill();
    end_sim();
  end
endmodule
`default_nettype wire
